// [rtl/esr_regs.sv]
`timescale 1ns/100ps
module esr_regs (
    input wire logic clock_i, // System clock, 20 MHz.
    input wire logic sys_rst_i, // Synchronous reset, active high.
    input esr_pkg::esr_bus_req_t bus_i, // Host register request.
    output logic [7:0] rdata_o, // Read data, one cycle after the strobe.
    input esr_pkg::esr_chk_evt_t chk_i, // Check engine events and syndromes.
    input esr_pkg::esr_seq_t seq_i, // Sequencer control-store events.
    input wire logic ignore_check_error_i, // Ignore control from the correction control register.
    input wire logic osc_core_i, // Free-running oscillator output from the clock block.
    input wire logic cpu_clk_core_i, // Processor clock from the clock block.
    input wire logic write_gate_core_i, // Write gate from the sequencer.
    output logic ecc_includes_sync_o, // Data sync byte enters the ECC.
    output logic crc_includes_sync_o, // ID sync byte enters the CRC.
    output logic poly_degree_select_o, // Zero degree five, one degree six.
    output logic interleave_way_select_o, // Zero three-way, one five-way.
    output logic sequencer_check_error_o, // Check error flag towards the sequencer.
    output logic oscillator_output_o, // Oscillator pin.
    output logic processor_clock_output_o, // Processor clock pin.
    output logic write_gate_output_o, // Write gate pin.
    output logic id_step_o, // One-cycle pulse that increments the ID counter.
    output logic addr_load_o, // Pulse: load address counter with jump target.
    output logic [4:0] jump_target_o // Jump target address.
);
    import esr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decode of the host strobes.

    // Write and read decodes of each register.
    logic wr_param, wr_status, wr_test, wr_jump, wr_start, rd_port;

    // Plain address decode; unmapped offsets simply produce no strobe.
    always_comb begin
        wr_param = 1'b0;
        wr_status = 1'b0;
        wr_test = 1'b0;
        wr_jump = 1'b0;
        wr_start = 1'b0;
        rd_port = 1'b0;
        if (bus_i.addr == ADDR_ECC_PARAMETERS) begin
            wr_param = bus_i.wr;
        end else if (bus_i.addr == ADDR_ECC_ERROR_STATUS) begin
            wr_status = bus_i.wr;
        end else if (bus_i.addr == ADDR_SYNDROME_READ_PORT) begin
            rd_port = bus_i.rd;
        end else if (bus_i.addr == ADDR_MANUFACTURING_TEST) begin
            wr_test = bus_i.wr;
        end else if (bus_i.addr == ADDR_JUMP_TARGET_ADDRESS) begin
            wr_jump = bus_i.wr;
        end else if (bus_i.addr == ADDR_SEQ_START) begin
            wr_start = bus_i.wr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ECC parameter register.

    // Four configuration bits, write only.
    logic [3:0] param_ff;

    // Parameter bits load from the host and come up in their documented defaults.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            param_ff <= RST_ECC_PARAMETERS;
        end else if (wr_param) begin
            param_ff <= bus_i.wdata[3:0];
        end
    end

    assign ecc_includes_sync_o = param_ff[POS_ECC_INCLUDES_SYNC];
    assign crc_includes_sync_o = param_ff[POS_CRC_INCLUDES_SYNC];
    assign poly_degree_select_o = param_ff[POS_POLY_DEGREE_SELECT];
    assign interleave_way_select_o = param_ff[POS_INTERLEAVE_WAY_SELECT];

    ////////////////////////////////////////////////////////////////////////
    // Error status flags.

    // Summary flags and per-lane flags.
    logic ecc_error_flag_ff;
    logic id_crc_error_flag_ff;
    logic [4:0] lane_flag_ff;
    logic seq_err_ff;

    // ECC summary: event sets, start register or new operation clears; set wins.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ecc_error_flag_ff <= 1'b0;
        end else if (chk_i.ecc_event && (chk_i.lane_err != 5'h00)) begin
            ecc_error_flag_ff <= 1'b1;
        end else if (wr_start || seq_i.op_start) begin
            ecc_error_flag_ff <= 1'b0;
        end
    end

    // ID CRC flag: set by any ID CRC error, ignore control has no say here.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            id_crc_error_flag_ff <= 1'b0;
        end else if (chk_i.crc_event) begin
            id_crc_error_flag_ff <= 1'b1;
        end else if (wr_start) begin
            id_crc_error_flag_ff <= 1'b0;
        end
    end

    // Lane flags: the host writes zero to clear, or one to reveal stored syndromes again.
    // A lane error in the same cycle as a host clear keeps the flag set.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            lane_flag_ff <= RST_LANE_FLAGS;
        end else begin
            if (wr_start) begin
                lane_flag_ff <= (chk_i.ecc_event ? chk_i.lane_err : 5'h00);
            end else if (wr_status) begin
                lane_flag_ff <= bus_i.wdata[4:0] | (chk_i.ecc_event ? chk_i.lane_err : 5'h00);
            end else if (chk_i.ecc_event) begin
                lane_flag_ff <= lane_flag_ff | chk_i.lane_err;
            end
        end
    end

    // Latched sequencer error; the ignore control forces it low so reading goes on.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            seq_err_ff <= 1'b0;
        end else if ((chk_i.ecc_event || chk_i.crc_event) && !ignore_check_error_i) begin
            seq_err_ff <= 1'b1;
        end else if (wr_start) begin
            seq_err_ff <= 1'b0;
        end
    end

    assign sequencer_check_error_o = seq_err_ff && !ignore_check_error_i;

    ////////////////////////////////////////////////////////////////////////
    // Syndrome storage and the sequential read port.

    // Syndrome bytes per lane; index 0 is the lowest byte of the lane.
    logic [7:0] synd_mem_ff [NUM_LANES][MAX_DEGREE];
    logic [2:0] lane_ff; // Lane now presented.
    logic [2:0] byte_ff; // Byte index within the lane, counting down.
    esr_sr_state_t sr_state_ff;
    logic [2:0] degree; // Bytes per lane.
    logic [2:0] lanes; // Lanes in this format.
    logic [4:0] visible; // Lanes whose flag is set and lie in the format.
    logic [2:0] next_lane; // Next visible lane above the current one.
    logic next_found;
    logic [2:0] first_lane; // Lowest visible lane.
    logic first_found;

    assign degree = param_ff[POS_POLY_DEGREE_SELECT] ? DEGREE_HIGH : DEGREE_LOW;
    assign lanes = param_ff[POS_INTERLEAVE_WAY_SELECT] ? LANES_HIGH : LANES_LOW;

    // Each lane is stored per entry; the check engine reports all syndromes at once.
    genvar gl, gb;
    generate
        for (gl = 0; gl < NUM_LANES; gl++) begin : g_lane
            assign visible[gl] = lane_flag_ff[gl] && (3'(gl) < lanes);
            for (gb = 0; gb < MAX_DEGREE; gb++) begin : g_byte
                always_ff @(posedge clock_i) begin
                    if (sys_rst_i) begin
                        synd_mem_ff[gl][gb] <= 8'h00;
                    end else if (chk_i.ecc_event && chk_i.lane_err[gl]) begin
                        synd_mem_ff[gl][gb] <= chk_i.syndromes[(gl*MAX_DEGREE+gb)*8 +: 8];
                    end
                end
            end
        end
    endgenerate

    // Search for the lowest visible lane and the next one above the current lane.
    always_comb begin
        first_lane = 3'h0;
        first_found = 1'b0;
        next_lane = 3'h0;
        next_found = 1'b0;
        for (int i = NUM_LANES - 1; i >= 0; i--) begin
            if (visible[i]) begin
                first_lane = 3'(i);
                first_found = 1'b1;
                if (3'(i) > lane_ff) begin
                    next_lane = 3'(i);
                    next_found = 1'b1;
                end
            end
        end
    end

    // Reader: IDLE seeks the first lane, SCAN hands out bytes high to low.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sr_state_ff <= SR_IDLE;
            lane_ff <= 3'h0;
            byte_ff <= 3'h0;
        end else if (seq_i.op_start || wr_start || wr_status) begin
            sr_state_ff <= SR_IDLE;
            lane_ff <= 3'h0;
            byte_ff <= 3'h0;
        end else begin
            case (sr_state_ff)
                SR_IDLE: begin
                    if (first_found) begin
                        sr_state_ff <= SR_SCAN;
                        lane_ff <= first_lane;
                        byte_ff <= 3'(degree - 3'h1);
                    end
                end
                SR_SCAN: begin
                    if (!visible[lane_ff]) begin
                        sr_state_ff <= SR_IDLE;
                    end else if (rd_port) begin
                        if (byte_ff != 3'h0) begin
                            byte_ff <= byte_ff - 3'h1;
                        end else if (next_found) begin
                            lane_ff <= next_lane;
                            byte_ff <= 3'(degree - 3'h1);
                        end else begin
                            sr_state_ff <= SR_IDLE;
                            lane_ff <= 3'h0;
                        end
                    end
                end
                default: begin
                    sr_state_ff <= SR_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Manufacturing test register.

    logic wg_block_ff; // Write gate held off.
    logic step_armed_ff; // An ID step is allowed.
    logic id_step_ff;

    // Code 80h or C0h blocks the write gate; only 00h or reset lifts the block.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            wg_block_ff <= 1'b0;
        end else if (wr_test) begin
            if (bus_i.wdata == TEST_CODE_WG_OFF || bus_i.wdata == TEST_CODE_ID_STEP) begin
                wg_block_ff <= 1'b1;
            end else if (bus_i.wdata == TEST_CODE_IDLE) begin
                wg_block_ff <= 1'b0;
            end
        end
    end

    // One ID step for the first C0h after reset or a 00h write; a 00h write rearms it.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            step_armed_ff <= 1'b1;
            id_step_ff <= 1'b0;
        end else begin
            id_step_ff <= 1'b0;
            if (wr_test && bus_i.wdata == TEST_CODE_ID_STEP && step_armed_ff) begin
                id_step_ff <= 1'b1;
                step_armed_ff <= 1'b0;
            end else if (wr_test && bus_i.wdata == TEST_CODE_IDLE) begin
                step_armed_ff <= 1'b1;
            end
        end
    end

    assign id_step_o = id_step_ff;
    // The forced clock levels last exactly the write cycle; pins are combinational by need.
    assign oscillator_output_o = wr_test ? 1'b0 : osc_core_i;
    assign processor_clock_output_o = wr_test ? 1'b1 : cpu_clk_core_i;
    assign write_gate_output_o = write_gate_core_i && !wg_block_ff;

    ////////////////////////////////////////////////////////////////////////
    // Jump target register: no reset on purpose, it keeps the last host value.

    logic [4:0] jump_ff;

    always_ff @(posedge clock_i) begin
        if (wr_jump) begin
            jump_ff <= bus_i.wdata[4:0];
        end
    end

    assign jump_target_o = jump_ff;
    assign addr_load_o = seq_i.instr_done && seq_i.jump_en;

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered one cycle after the strobe.

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd && bus_i.addr == ADDR_ECC_ERROR_STATUS) begin
            rdata_o <= {1'b0, ecc_error_flag_ff, id_crc_error_flag_ff, lane_flag_ff};
        end else if (rd_port && sr_state_ff == SR_SCAN && visible[lane_ff]) begin
            rdata_o <= synd_mem_ff[lane_ff][byte_ff];
        end else begin
            rdata_o <= 8'h00; // Write-only, unmapped, or nothing visible.
        end
    end

endmodule // esr_regs

// [rtl/esr_pkg.sv]
package esr_pkg;

    // Register offsets on the plain register port.
    localparam logic [7:0] ADDR_ECC_PARAMETERS = 8'h10;
    localparam logic [7:0] ADDR_ECC_ERROR_STATUS = 8'h11;
    localparam logic [7:0] ADDR_SYNDROME_READ_PORT = 8'h12;
    localparam logic [7:0] ADDR_MANUFACTURING_TEST = 8'h16;
    localparam logic [7:0] ADDR_JUMP_TARGET_ADDRESS = 8'h17;
    localparam logic [7:0] ADDR_SEQ_START = 8'h0C;

    // Field positions in the ECC parameter register.
    localparam int POS_ECC_INCLUDES_SYNC = 3;
    localparam int POS_CRC_INCLUDES_SYNC = 2;
    localparam int POS_POLY_DEGREE_SELECT = 1;
    localparam int POS_INTERLEAVE_WAY_SELECT = 0;

    // Field positions in the ECC error status register.
    localparam int POS_ECC_ERROR_FLAG = 6;
    localparam int POS_ID_CRC_ERROR_FLAG = 5;

    // Values after reset.
    localparam logic [3:0] RST_ECC_PARAMETERS = 4'hC;
    localparam logic [4:0] RST_LANE_FLAGS = 5'h00;

    // Test register command codes.
    localparam logic [7:0] TEST_CODE_IDLE = 8'h00;
    localparam logic [7:0] TEST_CODE_WG_OFF = 8'h80;
    localparam logic [7:0] TEST_CODE_ID_STEP = 8'hC0;

    // Geometry of the syndrome storage.
    localparam int NUM_LANES = 5;
    localparam int MAX_DEGREE = 6;
    localparam logic [2:0] DEGREE_LOW = 3'h5;
    localparam logic [2:0] DEGREE_HIGH = 3'h6;
    localparam logic [2:0] LANES_LOW = 3'h3;
    localparam logic [2:0] LANES_HIGH = 3'h5;

    // Host register port request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } esr_bus_req_t;

    // Check engine event report with the syndromes of a finished field.
    typedef struct packed {
        logic ecc_event;
        logic crc_event;
        logic [4:0] lane_err;
        logic [NUM_LANES*MAX_DEGREE*8-1:0] syndromes;
    } esr_chk_evt_t;

    // Sequencer control-store side signals.
    typedef struct packed {
        logic op_start;
        logic stopped;
        logic instr_done;
        logic jump_en;
    } esr_seq_t;

    // Syndrome reader state.
    typedef enum logic [1:0] {
        SR_IDLE = 2'b01,
        SR_SCAN = 2'b10
    } esr_sr_state_t;

endpackage

// [tb/esr_host_model.sv]
`timescale 1ns/100ps
// Host processor on the register port; every request is launched right after a rising edge.
module esr_host_model (
    input wire logic clock_i, // System clock.
    output esr_pkg::esr_bus_req_t bus_o, // Request towards the block.
    input wire logic [7:0] rdata_i // Read data from the block.
);
    import esr_pkg::*;
    initial bus_o = '0;
    // One-cycle write strobe; the block never stalls, so no wait is needed.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        bus_o <= {a, d, 1'b1, 1'b0};
        @(posedge clock_i);
        bus_o.wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe, so it is taken mid-cycle there.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        bus_o <= {a, 8'h00, 1'b0, 1'b1};
        @(posedge clock_i);
        bus_o.rd <= 1'b0;
        @(negedge clock_i);
        d = rdata_i;
    endtask
endmodule // esr_host_model

// [tb/esr_chk_assertions.sv]
`timescale 1ns/100ps
module esr_chk (
    input wire logic clock_i, // Clock.
    input wire logic sys_rst_i, // Reset.
    input esr_pkg::esr_bus_req_t bus_i, // Host request.
    input esr_pkg::esr_seq_t seq_i, // Sequencer events.
    input wire logic ignore_check_error_i, // Ignore control.
    input wire logic osc_core_i, // Core oscillator.
    input wire logic cpu_clk_core_i, // Core processor clock.
    input wire logic write_gate_core_i, // Core write gate.
    input wire logic ecc_includes_sync_o, // Parameter bit 3.
    input wire logic crc_includes_sync_o, // Parameter bit 2.
    input wire logic poly_degree_select_o, // Parameter bit 1.
    input wire logic interleave_way_select_o, // Parameter bit 0.
    input wire logic sequencer_check_error_o, // Sequencer error.
    input wire logic oscillator_output_o, // Oscillator pin.
    input wire logic processor_clock_output_o, // Processor clock pin.
    input wire logic write_gate_output_o, // Write gate pin.
    input wire logic id_step_o, // ID step pulse.
    input wire logic addr_load_o, // Jump load pulse.
    input wire logic [4:0] jump_target_o // Jump target.
);
    import esr_pkg::*;
    logic test_wr; // Any write to the test register.
    logic [3:0] par; // Parameter outputs gathered.
    logic [3:0] wd4; // Low write data nibble.
    logic armed_ff; // A step is allowed.
    logic [4:0] tgt_ff; // Last jump target written.
    logic known_ff = 1'b0; // Not reset: the jump register survives reset.
    assign test_wr = bus_i.wr && bus_i.addr == ADDR_MANUFACTURING_TEST;
    assign par = {ecc_includes_sync_o, crc_includes_sync_o, poly_degree_select_o, interleave_way_select_o};
    assign wd4 = bus_i.wdata[3:0];
    // Step is rearmed only by reset or the idle code.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) armed_ff <= 1'b1;
        else if (test_wr && bus_i.wdata == TEST_CODE_IDLE) armed_ff <= 1'b1;
        else if (test_wr && bus_i.wdata == TEST_CODE_ID_STEP) armed_ff <= 1'b0;
    end
    // Shadow of the jump register, kept across reset.
    always @(posedge clock_i) begin
        if (bus_i.wr && bus_i.addr == ADDR_JUMP_TARGET_ADDRESS) begin
            tgt_ff <= bus_i.wdata[4:0];
            known_ff <= 1'b1;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_code(logic [7:0] c);
        test_wr && bus_i.wdata == c;
    endsequence
    AST_PARAM_RST: assert property ($fell(sys_rst_i) |-> par == RST_ECC_PARAMETERS)
        else $error("Parameter bits wrong after reset.");
    AST_PARAM_WR: assert property (bus_i.wr && bus_i.addr == ADDR_ECC_PARAMETERS |=> par == $past(wd4))
        else $error("Parameter write not applied.");
    AST_CLK_FORCE: assert property (test_wr |-> !oscillator_output_o && processor_clock_output_o)
        else $error("Clock pins not forced during test write.");
    AST_CLK_PASS: assert property (!test_wr |-> oscillator_output_o == osc_core_i
        && processor_clock_output_o == cpu_clk_core_i)
        else $error("Clock pins forced outside test write.");
    AST_WG_OFF: assert property (s_code(TEST_CODE_WG_OFF) |=> !write_gate_output_o)
        else $error("Write gate not blocked.");
    AST_WG_ON: assert property (s_code(TEST_CODE_IDLE) |=> write_gate_output_o == write_gate_core_i)
        else $error("Write gate not released.");
    AST_STEP: assert property (s_code(TEST_CODE_ID_STEP) and armed_ff |=> id_step_o ##1 !id_step_o)
        else $error("ID step pulse wrong.");
    AST_NO_STEP: assert property (s_code(TEST_CODE_ID_STEP) and !armed_ff |=> !id_step_o)
        else $error("ID step without rearm.");
    AST_JUMP: assert property (seq_i.instr_done && seq_i.jump_en && known_ff
        |-> addr_load_o && jump_target_o == tgt_ff)
        else $error("Jump load wrong.");
    AST_NO_JUMP: assert property (!(seq_i.instr_done && seq_i.jump_en) |-> !addr_load_o)
        else $error("Spurious jump load.");
    AST_IGNORE: assert property (ignore_check_error_i |-> !sequencer_check_error_o)
        else $error("Sequencer error not ignored.");
endmodule // esr_chk

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
    import esr_pkg::*;
    logic clock_i = 1'b0; // Bench clock, 50 ns period.
    logic sys_rst_i = 1'b1; // Reset held from time zero.
    esr_bus_req_t bus; // Host request.
    logic [7:0] rdata; // Read data.
    esr_chk_evt_t chk = '0; // Check engine stimulus.
    esr_chk_evt_t ev = '0; // Prepared event with known syndromes.
    esr_seq_t seq = '0; // Sequencer stimulus.
    logic ign = 1'b0, osc_c = 1'b0, cpu_c = 1'b0, wg_c = 1'b1; // Core levels.
    logic ecc_s, crc_s, deg, way, serr, osc_o, cpu_o, wg_o, step, load; // Outputs.
    logic [4:0] tgt; // Jump target.
    int err_count = 0, cmp_count = 0, cyc = 0, steps = 0; // Bookkeeping.
    esr_regs esr_regs_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus_i(bus), .rdata_o(rdata), .chk_i(chk),
        .seq_i(seq), .ignore_check_error_i(ign), .osc_core_i(osc_c), .cpu_clk_core_i(cpu_c),
        .write_gate_core_i(wg_c), .ecc_includes_sync_o(ecc_s), .crc_includes_sync_o(crc_s),
        .poly_degree_select_o(deg), .interleave_way_select_o(way), .sequencer_check_error_o(serr),
        .oscillator_output_o(osc_o), .processor_clock_output_o(cpu_o), .write_gate_output_o(wg_o),
        .id_step_o(step), .addr_load_o(load), .jump_target_o(tgt));
    esr_host_model host_i (.clock_i(clock_i), .bus_o(bus), .rdata_i(rdata));
    ////////////////////////////////////////////////////////////////////////////////
    always #25 clock_i = ~clock_i;
    // Core clocks toggle so pass-through is visible; steps are counted; a hang is cut off.
    always @(posedge clock_i) begin
        osc_c <= ~osc_c;
        cpu_c <= osc_c;
        cyc++;
        if (step === 1'b1) steps++;
        if (cyc == 3000) begin
            err_count++;
            give_verdict();
        end
    end
    function automatic logic [7:0] syn(input int l, input int b);
        return {1'b1, 3'(l), 4'(b)};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("BAD %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host_i.rd(a, v);
        check(v, exp);
    endtask
    task automatic fire(input logic [4:0] lanes, input logic crc);
        ev.ecc_event = 1'b1;
        ev.crc_event = crc;
        ev.lane_err = lanes;
        @(posedge clock_i) chk <= ev;
        @(posedge clock_i) chk <= '0;
        repeat (2) @(posedge clock_i);
    endtask
    task automatic do_reset;
        sys_rst_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_params;
        rd_chk(ADDR_ECC_ERROR_STATUS, 8'h00);
        rd_chk(ADDR_ECC_PARAMETERS, 8'h00);
        check({4'h0, ecc_s, crc_s, deg, way}, {4'h0, RST_ECC_PARAMETERS});
        host_i.wr(ADDR_ECC_PARAMETERS, 8'h03);
        @(negedge clock_i) check({4'h0, ecc_s, crc_s, deg, way}, 8'h03);
        host_i.wr(ADDR_ECC_PARAMETERS, 8'h0E);
        @(negedge clock_i) check({4'h0, ecc_s, crc_s, deg, way}, 8'h0E);
        rd_chk(8'h05, 8'h00);
        $display("params test done");
    endtask
    // Degree six, three lanes; lanes 0 and 2 in error, ignore control held high.
    task automatic t_syndrome;
        @(posedge clock_i) seq <= 4'b0100;
        ign <= 1'b1;
        fire(5'b00101, 1'b0);
        check({7'h0, serr}, 8'h00);
        rd_chk(ADDR_ECC_ERROR_STATUS, 8'h45);
        for (int l = 0; l < 3; l++)
            if (ev.lane_err[l])
                for (int b = 5; b >= 0; b--) rd_chk(ADDR_SYNDROME_READ_PORT, syn(l, b));
        host_i.wr(ADDR_ECC_ERROR_STATUS, 8'h04);
        rd_chk(ADDR_ECC_ERROR_STATUS, 8'h44);
        for (int b = 5; b >= 0; b--) rd_chk(ADDR_SYNDROME_READ_PORT, syn(2, b));
        host_i.wr(ADDR_ECC_ERROR_STATUS, 8'h05);
        rd_chk(ADDR_SYNDROME_READ_PORT, syn(0, 5));
        // An error seen under the ignore control is never latched, so dropping the control shows none.
        @(posedge clock_i) ign <= 1'b0;
        @(negedge clock_i) check({7'h0, serr}, 8'h00);
        $display("syndrome test done");
    endtask
    // A new operation drops only the summary; the start register clears everything.
    task automatic t_clear;
        host_i.wr(ADDR_SEQ_START, 8'h00);
        rd_chk(ADDR_ECC_ERROR_STATUS, 8'h00);
        check({7'h0, serr}, 8'h00);
        fire(5'b00010, 1'b1);
        rd_chk(ADDR_ECC_ERROR_STATUS, 8'h62);
        check({7'h0, serr}, 8'h01);
        @(posedge clock_i) seq <= 4'b1100;
        @(posedge clock_i) seq <= 4'b0100;
        rd_chk(ADDR_ECC_ERROR_STATUS, 8'h22);
        rd_chk(ADDR_SYNDROME_READ_PORT, syn(1, 5));
        host_i.wr(ADDR_SEQ_START, 8'h00);
        rd_chk(ADDR_ECC_ERROR_STATUS, 8'h00);
        check({7'h0, serr}, 8'h00);
        $display("clear test done");
    endtask
    task automatic t_test;
        int s0;
        host_i.wr(ADDR_MANUFACTURING_TEST, TEST_CODE_WG_OFF);
        @(negedge clock_i) check({7'h0, wg_o}, 8'h00);
        check({6'h0, osc_o, cpu_o}, {6'h0, osc_c, cpu_c});
        host_i.wr(ADDR_MANUFACTURING_TEST, 8'h33);
        @(negedge clock_i) check({7'h0, wg_o}, 8'h00);
        host_i.wr(ADDR_MANUFACTURING_TEST, TEST_CODE_IDLE);
        @(negedge clock_i) check({7'h0, wg_o}, 8'h01);
        s0 = steps;
        host_i.wr(ADDR_MANUFACTURING_TEST, TEST_CODE_ID_STEP);
        @(negedge clock_i) check({7'h0, wg_o}, 8'h00);
        host_i.wr(ADDR_MANUFACTURING_TEST, TEST_CODE_ID_STEP);
        host_i.wr(ADDR_MANUFACTURING_TEST, TEST_CODE_IDLE);
        host_i.wr(ADDR_MANUFACTURING_TEST, TEST_CODE_ID_STEP);
        host_i.wr(ADDR_MANUFACTURING_TEST, TEST_CODE_IDLE);
        repeat (2) @(posedge clock_i);
        check(8'(steps - s0), 8'h02);
        $display("test register done");
    endtask
    task automatic t_jump;
        host_i.wr(ADDR_JUMP_TARGET_ADDRESS, 8'h0C);
        repeat (2) begin
            @(posedge clock_i) seq <= 4'b0111;
            @(negedge clock_i) check({load, 2'b00, tgt}, 8'h8C);
            @(posedge clock_i) seq <= 4'b0100;
            do_reset();
        end
        check({4'h0, ecc_s, crc_s, deg, way}, {4'h0, RST_ECC_PARAMETERS});
        $display("jump test done");
    endtask
    initial begin
        for (int i = 0; i < NUM_LANES * MAX_DEGREE; i++) ev.syndromes[i*8 +: 8] = syn(i / 6, i % 6);
        do_reset();
        t_params();
        t_syndrome();
        t_clear();
        t_test();
        t_jump();
        give_verdict();
    end
endmodule // testbench
bind esr_regs esr_chk esr_chk_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i), .seq_i(seq_i),
    .ignore_check_error_i(ignore_check_error_i), .osc_core_i(osc_core_i), .cpu_clk_core_i(cpu_clk_core_i),
    .write_gate_core_i(write_gate_core_i), .ecc_includes_sync_o(ecc_includes_sync_o),
    .crc_includes_sync_o(crc_includes_sync_o), .poly_degree_select_o(poly_degree_select_o),
    .interleave_way_select_o(interleave_way_select_o), .sequencer_check_error_o(sequencer_check_error_o),
    .oscillator_output_o(oscillator_output_o), .processor_clock_output_o(processor_clock_output_o),
    .write_gate_output_o(write_gate_output_o), .id_step_o(id_step_o), .addr_load_o(addr_load_o),
    .jump_target_o(jump_target_o));
